// File: design/img_ctrl.sv
// Interrupt controller with host message and general pin registers on AHB-Lite
//
// The register addresses and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Four message registers, three data bits each
// - Message write pulses its own event once
// - Pin register reads pin level and stored output
// - Bits 30-25 input pins; 24-20, 15-14 empty
// - Bit 13 retry giveup, bit 12 parity
// - Bit 11 target error, bit 10 initiator error
// - Bit 9 follows active bus interrupt pin
// - Bits 8-6 copier fault, done, ready levels
// - Bits 5-4 DMA finished and ready levels
// - Bits 3-0 are the message events
// - Status shows latch for edge-sensed sources
// - Set and clear ports touch one-bits only
// - Clear port also resets matching edge latches
// - Invert applied before the edge latch
// - Edge select picks latch; latch unaffected
// - Route bit zero line a, one line b
// - Config bit mirrors line b onto bus
module img_ctrl
    import img_pkg::*;
#(
    parameter int GPIO_N = IMG_GPIO_N,
    parameter int INPUT_ONLY_PINS_N = IMG_INPUT_ONLY_PINS_N
) (
    input  wire logic                    clock,
    input  wire logic                    nrst,
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic [31:0]                  hrdata,
    input  wire logic [INPUT_ONLY_PINS_N-1:0]       input_only_pins,
    input  wire logic [GPIO_N-1:0]       gpio_in,
    output logic [GPIO_N-1:0]            gpio_out,
    output logic [GPIO_N-1:0]            gpio_oe,
    input  wire logic                    retry_giveup_event,
    input  wire logic                    parity_error_event,
    input  wire logic                    target_error_event,
    input  wire logic                    initiator_error_event,
    input  wire logic                    bus_irq_in_n,
    input  wire logic                    copier_fault,
    input  wire logic                    copier_all_done,
    input  wire logic                    copier_can_accept,
    input  wire logic                    dma_all_done,
    input  wire logic                    dma_can_accept,
    output logic                         cpu_irq_line_a_n,
    output logic                         cpu_irq_line_b_n,
    output logic                         bus_irq_out,
    output logic                         bus_irq_oe
);
    // The bit layout is fixed by the interrupt register map
    if (GPIO_N != IMG_GPIO_N || INPUT_ONLY_PINS_N != IMG_INPUT_ONLY_PINS_N) begin : g_chk
        $error("img_ctrl: pin counts must match the interrupt bit layout");
    end

    function automatic logic hit(input img_phase_t p, input logic [IMG_IW-1:0] r);
        hit = (p.idx == r);
    endfunction

    // Bus state
    img_state_t                  state_ff, nxt_state;
    img_phase_t                  phase_ff, nxt_phase;
    logic [31:0]                 rdata_ff, nxt_rdata;
    // Register state
    logic [IMG_MBOX_W-1:0]       msg_ff [IMG_MBOX_N];
    logic [IMG_MBOX_W-1:0]       nxt_msg [IMG_MBOX_N];
    logic [GPIO_N-1:0]           out_ff, nxt_out;
    logic [GPIO_N-1:0]           dir_ff, nxt_dir;
    logic [31:0]                 en_ff, nxt_en;
    logic [31:0]                 inv_ff, nxt_inv;
    logic [31:0]                 edge_ff, nxt_edge;
    logic [31:0]                 route_ff, nxt_route;
    logic                        mirror_ff, nxt_mirror;
    // Interrupt state
    logic [31:0]                 prev_ff, latch_ff, nxt_latch;
    logic                        irq_a_ff, irq_b_ff;
    logic                        nxt_irq_a, nxt_irq_b;
    // Combinational
    logic                        take;
    logic                        wr_go;
    logic [IMG_MBOX_N-1:0]       mbox_pulse;
    logic [31:0]                 src, adj, rise, status, wr_clr;
    logic [31:0]                 dir_word, pin_word;

    assign take  = hsel && htrans[1] && hready;
    assign wr_go = (state_ff == IMG_S_WDATA);
    assign hreadyout = (state_ff != IMG_S_RWAIT);
    assign hresp     = 1'b0;
    assign hrdata    = rdata_ff;

    for (genvar i = 0; i < IMG_MBOX_N; i++) begin : g_mbox
        // Pulse lasts exactly the write's data phase
        assign mbox_pulse[i] = wr_go && hit(phase_ff, IMG_R_MSG0 + 6'(i));
    end

    // Source vector; unconnected bits stay zero
    always_comb begin
        src = IMG_RST_ZERO;
        src[IMG_B_INPUT_ONLY_PINS +: IMG_INPUT_ONLY_PINS_N] = input_only_pins;
        src[IMG_B_GPIO +: IMG_GPIO_N] = gpio_in;
        src[IMG_B_RETRY]  = retry_giveup_event;
        src[IMG_B_PARITY] = parity_error_event;
        src[IMG_B_TGTERR] = target_error_event;
        src[IMG_B_INIERR] = initiator_error_event;
        src[IMG_B_BUSIRQ] = ~bus_irq_in_n;
        src[IMG_B_CPYERR] = copier_fault;
        src[IMG_B_CPYEMP] = copier_all_done;
        src[IMG_B_CPYRDY] = copier_can_accept;
        src[IMG_B_DMAEMP] = dma_all_done;
        src[IMG_B_DMARDY] = dma_can_accept;
        src[IMG_B_MBOX +: IMG_MBOX_N] = mbox_pulse;
    end

    assign adj    = (src ^ inv_ff) & IMG_M_IMPL;
    assign rise   = adj & ~prev_ff;
    assign status = ((edge_ff & latch_ff) | (~edge_ff & adj)) & IMG_M_IMPL;
    assign wr_clr = (wr_go && hit(phase_ff, IMG_R_ENCLR)) ? hwdata : IMG_RST_ZERO;

    // A new edge in the clear cycle survives the clear
    assign nxt_latch = ((latch_ff & ~wr_clr) | rise) & IMG_M_IMPL;

    always_comb begin
        dir_word = IMG_RST_ZERO;
        dir_word[GPIO_N-1:0] = dir_ff;
        dir_word[IMG_P_INPUT_ONLY_PINS +: INPUT_ONLY_PINS_N] = '1;
        pin_word = IMG_RST_ZERO;
        pin_word[IMG_P_OUT +: GPIO_N] = out_ff;
        pin_word[IMG_P_LVL +: GPIO_N] = gpio_in;
    end

    // Bus phase and read data
    always_comb begin
        nxt_state = state_ff;
        nxt_phase = phase_ff;
        nxt_rdata = rdata_ff;
        case (state_ff)
            IMG_S_RWAIT: begin
                nxt_rdata = IMG_RST_ZERO;
                case (phase_ff.idx)
                    IMG_R_PINLVL: nxt_rdata = pin_word;
                    IMG_R_PINDIR: nxt_rdata = dir_word;
                    IMG_R_STATUS: nxt_rdata = status;
                    IMG_R_ENABLE: nxt_rdata = en_ff;
                    IMG_R_INVERT: nxt_rdata = inv_ff;
                    IMG_R_EDGE:   nxt_rdata = edge_ff;
                    IMG_R_ROUTE:  nxt_rdata = route_ff;
                    IMG_R_GENCFG: nxt_rdata[IMG_G_MIRROR] = mirror_ff;
                    default: begin
                        if (phase_ff.idx <= IMG_R_MSG3) begin
                            nxt_rdata[IMG_MBOX_W-1:0] = msg_ff[phase_ff.idx[1:0]];
                        end
                    end
                endcase
                nxt_state = IMG_S_RDATA;
            end
            default: begin
                // Read costs one wait state so the data comes from a flop
                if (take) begin
                    nxt_phase.wr  = hwrite;
                    nxt_phase.idx = haddr[IMG_IW+1:2];
                    nxt_state = hwrite ? IMG_S_WDATA : IMG_S_RWAIT;
                end else begin
                    nxt_state = IMG_S_IDLE;
                end
            end
        endcase
    end

    // Register writes, committed in the data phase
    always_comb begin
        nxt_out    = out_ff;
        nxt_dir    = dir_ff;
        nxt_en     = en_ff;
        nxt_inv    = inv_ff;
        nxt_edge   = edge_ff;
        nxt_route  = route_ff;
        nxt_mirror = mirror_ff;
        for (int i = 0; i < IMG_MBOX_N; i++) begin
            nxt_msg[i] = mbox_pulse[i] ? hwdata[IMG_MBOX_W-1:0] : msg_ff[i];
        end
        if (wr_go) begin
            case (phase_ff.idx)
                IMG_R_PINLVL: nxt_out = hwdata[IMG_P_OUT +: GPIO_N];
                IMG_R_PINDIR: nxt_dir = hwdata[GPIO_N-1:0];
                IMG_R_ENSET:  nxt_en  = (en_ff | hwdata) & IMG_M_IMPL;
                IMG_R_ENCLR:  nxt_en  = en_ff & ~hwdata;
                IMG_R_INVERT: nxt_inv = hwdata & IMG_M_POL;
                // Changing the select never touches the latch
                IMG_R_EDGE:   nxt_edge = (hwdata & IMG_M_IMPL) | IMG_M_EDGE1;
                IMG_R_ROUTE:  nxt_route = hwdata & IMG_M_IMPL;
                IMG_R_GENCFG: nxt_mirror = hwdata[IMG_G_MIRROR];
                default: begin
                    nxt_out = out_ff;
                end
            endcase
        end
        nxt_irq_a = |(status & en_ff & ~route_ff);
        nxt_irq_b = |(status & en_ff & route_ff);
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_ff  <= IMG_S_IDLE;
            phase_ff  <= '0;
            rdata_ff  <= IMG_RST_ZERO;
            out_ff    <= '0;
            dir_ff    <= IMG_RST_DIR;
            en_ff     <= IMG_RST_ZERO;
            inv_ff    <= IMG_RST_ZERO;
            edge_ff   <= IMG_M_EDGE1;
            route_ff  <= IMG_RST_ZERO;
            mirror_ff <= 1'b0;
            prev_ff   <= IMG_RST_ZERO;
            latch_ff  <= IMG_RST_ZERO;
            irq_a_ff  <= 1'b0;
            irq_b_ff  <= 1'b0;
            for (int i = 0; i < IMG_MBOX_N; i++) begin
                msg_ff[i] <= '0;
            end
        end else begin
            state_ff  <= nxt_state;
            phase_ff  <= nxt_phase;
            rdata_ff  <= nxt_rdata;
            out_ff    <= nxt_out;
            dir_ff    <= nxt_dir;
            en_ff     <= nxt_en;
            inv_ff    <= nxt_inv;
            edge_ff   <= nxt_edge;
            route_ff  <= nxt_route;
            mirror_ff <= nxt_mirror;
            prev_ff   <= adj;
            latch_ff  <= nxt_latch;
            irq_a_ff  <= nxt_irq_a;
            irq_b_ff  <= nxt_irq_b;
            for (int i = 0; i < IMG_MBOX_N; i++) begin
                msg_ff[i] <= nxt_msg[i];
            end
        end
    end

    assign gpio_out = out_ff;
    assign gpio_oe  = ~dir_ff;
    assign cpu_irq_line_a_n = ~irq_a_ff;
    assign cpu_irq_line_b_n = ~irq_b_ff;
    // Open-drain bus line: only ever pulled low
    assign bus_irq_out = 1'b0;
    assign bus_irq_oe  = mirror_ff && irq_b_ff;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_read_take;
        take && !hwrite;
    endsequence
    sequence s_read_answer;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence s_msg0_write;
        wr_go && hit(phase_ff, IMG_R_MSG0);
    endsequence

    a_read_wait_one: assert property (s_read_take |=> s_read_answer)
        else $error("read answer not after one wait state");
    a_mbox_latches: assert property (s_msg0_write |=> latch_ff[IMG_B_MBOX])
        else $error("message write did not latch its event");
    a_mbox_stores: assert property (s_msg0_write |=> msg_ff[0] == $past(hwdata[IMG_MBOX_W-1:0]))
        else $error("message register did not store three bits");
    a_pin_readback: assert property (state_ff == IMG_S_RDATA && hit(phase_ff, IMG_R_PINLVL)
        |-> hrdata[IMG_P_OUT +: GPIO_N] == gpio_out)
        else $error("pin register low bits differ from outputs");
    a_enable_set: assert property (wr_go && hit(phase_ff, IMG_R_ENSET)
        |=> en_ff == ($past(en_ff | hwdata) & IMG_M_IMPL))
        else $error("enable set touched wrong bits");
    a_clear_latch: assert property (wr_go && hit(phase_ff, IMG_R_ENCLR)
        |=> (latch_ff & $past(hwdata & ~rise)) == IMG_RST_ZERO)
        else $error("clear write left a latch set");
    a_edge_sets: assert property (rise != IMG_RST_ZERO
        |=> (latch_ff & $past(rise)) == $past(rise))
        else $error("rising source did not set its latch");
    a_line_a_level: assert property (|(status & en_ff & ~route_ff) |=> !cpu_irq_line_a_n)
        else $error("line a not asserted for routed condition");
    a_line_b_idle: assert property (!(|(status & en_ff & route_ff)) |=> cpu_irq_line_b_n)
        else $error("line b asserted with nothing routed");
    a_bus_mirror: assert property (mirror_ff && !cpu_irq_line_b_n |-> bus_irq_oe)
        else $error("bus line not mirroring line b");
    a_invert_ro: assert property ((inv_ff & ~IMG_M_POL) == IMG_RST_ZERO)
        else $error("internal invert bit became set");
endmodule

`default_nettype wire

// File: inc/img_pkg.sv
// Constants and types for the interrupt, mailbox and pin block
package img_pkg;
    localparam int          IMG_DW        = 32;
    localparam int          IMG_IW        = 6;
    localparam int          IMG_MBOX_N    = 4;
    localparam int          IMG_MBOX_W    = 3;
    localparam int          IMG_GPIO_N    = 4;
    localparam int          IMG_INPUT_ONLY_PINS_N    = 6;
    // Word indexes; byte address is four times the index
    localparam logic [5:0]  IMG_R_MSG0    = 6'h00;
    localparam logic [5:0]  IMG_R_MSG3    = 6'h03;
    localparam logic [5:0]  IMG_R_PINLVL  = 6'h04;
    localparam logic [5:0]  IMG_R_PINDIR  = 6'h05;
    localparam logic [5:0]  IMG_R_STATUS  = 6'h06;
    localparam logic [5:0]  IMG_R_ENABLE  = 6'h07;
    localparam logic [5:0]  IMG_R_ENSET   = 6'h08;
    localparam logic [5:0]  IMG_R_ENCLR   = 6'h09;
    localparam logic [5:0]  IMG_R_INVERT  = 6'h0A;
    localparam logic [5:0]  IMG_R_EDGE    = 6'h0B;
    localparam logic [5:0]  IMG_R_ROUTE   = 6'h0C;
    localparam logic [5:0]  IMG_R_GENCFG  = 6'h0D;
    // Interrupt bit positions
    localparam int          IMG_B_INPUT_ONLY_PINS    = 25;
    localparam int          IMG_B_GPIO    = 16;
    localparam int          IMG_B_RETRY   = 13;
    localparam int          IMG_B_PARITY  = 12;
    localparam int          IMG_B_TGTERR  = 11;
    localparam int          IMG_B_INIERR  = 10;
    localparam int          IMG_B_BUSIRQ  = 9;
    localparam int          IMG_B_CPYERR  = 8;
    localparam int          IMG_B_CPYEMP  = 7;
    localparam int          IMG_B_CPYRDY  = 6;
    localparam int          IMG_B_DMAEMP  = 5;
    localparam int          IMG_B_DMARDY  = 4;
    localparam int          IMG_B_MBOX    = 0;
    // Pin level register: stored outputs low, pin levels high
    localparam int          IMG_P_OUT     = 0;
    localparam int          IMG_P_LVL     = 16;
    localparam int          IMG_P_INPUT_ONLY_PINS    = 4;
    localparam int          IMG_G_MIRROR  = 0;
    // Masks of implemented and writable interrupt bits
    localparam logic [31:0] IMG_M_IMPL    = 32'h7E0F_3FFF;
    localparam logic [31:0] IMG_M_POL     = 32'h7E0F_0200;
    localparam logic [31:0] IMG_M_EDGE1   = 32'h0000_000F;
    localparam logic [31:0] IMG_RST_ZERO  = 32'h0000_0000;
    localparam logic [3:0]  IMG_RST_DIR   = 4'hF;
    // Bus phase tracking
    typedef enum logic [1:0] {
        IMG_S_IDLE  = 2'b00,
        IMG_S_RWAIT = 2'b01,
        IMG_S_RDATA = 2'b11,
        IMG_S_WDATA = 2'b10
    } img_state_t;
    typedef struct packed {
        logic              wr;
        logic [IMG_IW-1:0] idx;
    } img_phase_t;
endpackage

// File: sim/img_far_end.sv
// Far-side model of the general pins and the open-drain bus interrupt line
`timescale 1ns/1ps
`default_nettype none

module img_far_end (
    input  wire logic [3:0] gpio_out,
    input  wire logic [3:0] gpio_oe,
    input  wire logic       bus_irq_out,
    input  wire logic       bus_irq_oe,
    input  wire logic [3:0] ext_val,
    input  wire logic       ext_en,
    input  wire logic       ext_irq,
    output logic [3:0]      gpio_in,
    output logic            bus_irq_in_n
);
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (gpio_oe[i] && ext_en)
                gpio_in[i] = gpio_out[i] & ext_val[i]; // Contention, low wins
            else if (gpio_oe[i])
                gpio_in[i] = gpio_out[i];
            else if (ext_en)
                gpio_in[i] = ext_val[i];
            else
                gpio_in[i] = 1'b1; // Released pins float to the pull-up
        end
    end
    // Pulled up unless some party pulls low
    assign bus_irq_in_n = ~(ext_irq | (bus_irq_oe & ~bus_irq_out));
endmodule

`default_nettype wire

// File: sim/img_ctrl_tb.sv
// Self-checking bench for the interrupt, mailbox and pin block
`timescale 1ns/1ps
`default_nettype none

module img_ctrl_tb
    import img_pkg::*;
;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] src = 32'h0;
    logic        ext_en = 1'b1;
    wire         hreadyout;
    wire         hresp;
    wire  [31:0] hrdata;
    wire  [3:0]  gpio_in;
    wire  [3:0]  gpio_out;
    wire  [3:0]  gpio_oe;
    wire         line_a_n;
    wire         line_b_n;
    wire         bus_irq_out;
    wire         bus_irq_oe;
    wire         bus_irq_in_n;
    int          num_errors = 0;
    int          compares = 0;

    always #5 clock = ~clock;

    img_ctrl dut (.clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .input_only_pins(src[30:25]),
        .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .retry_giveup_event(src[13]), .parity_error_event(src[12]),
        .target_error_event(src[11]), .initiator_error_event(src[10]),
        .bus_irq_in_n(bus_irq_in_n), .copier_fault(src[8]), .copier_all_done(src[7]),
        .copier_can_accept(src[6]), .dma_all_done(src[5]), .dma_can_accept(src[4]),
        .cpu_irq_line_a_n(line_a_n), .cpu_irq_line_b_n(line_b_n),
        .bus_irq_out(bus_irq_out), .bus_irq_oe(bus_irq_oe));

    img_far_end far (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .bus_irq_out(bus_irq_out),
        .bus_irq_oe(bus_irq_oe), .ext_val(src[19:16]), .ext_en(ext_en), .ext_irq(src[9]),
        .gpio_in(gpio_in), .bus_irq_in_n(bus_irq_in_n));

    task automatic stop_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Samples ready at the edge, as the bus master does
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge clock);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                num_errors++;
                $display("ERROR %0t bus wait ran out", $time);
                stop_test();
            end
            @(posedge clock);
        end
    endtask

    task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, idx, 2'b00};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, idx, d, r);
    endtask

    task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, idx, 32'h0, r);
        chk(r, exp);
    endtask

    // Interrupt path needs two edges; one spare
    task automatic settle();
        repeat (3) @(posedge clock);
    endtask

    initial begin
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        rdc(IMG_R_STATUS, 32'h0);
        rdc(IMG_R_ENABLE, 32'h0);
        rdc(IMG_R_INVERT, 32'h0);
        rdc(IMG_R_EDGE, 32'h0000_000F);
        rdc(IMG_R_ROUTE, 32'h0);
        rdc(IMG_R_PINDIR, 32'h0000_03FF);
        rdc(IMG_R_ENSET, 32'h0);
        rdc(6'h3F, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(IMG_R_MSG0 + 6'(i), 32'hFFFF_FFF8 | 32'(i));
            rdc(IMG_R_MSG0 + 6'(i), 32'(i));
        end
        rdc(IMG_R_STATUS, 32'h0000_000F);
        wr(IMG_R_ENSET, 32'h3);
        wr(IMG_R_ENCLR, 32'h1);
        rdc(IMG_R_ENABLE, 32'h2);
        rdc(IMG_R_STATUS, 32'h0000_000E);
        chk({30'h0, line_b_n, line_a_n}, 32'h2);
        wr(IMG_R_ENCLR, 32'hE);
        settle();
        chk({30'h0, line_b_n, line_a_n}, 32'h3);
        wr(IMG_R_INVERT, 32'hFFFF_FFFF);
        rdc(IMG_R_INVERT, IMG_M_POL);
        rdc(IMG_R_STATUS, IMG_M_POL);
        wr(IMG_R_INVERT, 32'h0);
        for (int b = 4; b < 31; b++) begin
            src <= 32'h1 << b;
            settle();
            rdc(IMG_R_STATUS, (32'h1 << b) & IMG_M_IMPL);
        end
        src <= 32'h0;
        wr(IMG_R_ENCLR, 32'hFFFF_FFFF);
        rdc(IMG_R_STATUS, 32'h0);
        wr(IMG_R_EDGE, 32'h0000_100F);
        rdc(IMG_R_EDGE, 32'h0000_100F);
        src <= 32'h0000_1000;
        settle();
        src <= 32'h0;
        settle();
        rdc(IMG_R_STATUS, 32'h0000_1000);
        wr(IMG_R_ROUTE, 32'h0000_1000);
        wr(IMG_R_GENCFG, 32'h1);
        wr(IMG_R_ENSET, 32'h0000_1000);
        settle();
        chk({30'h0, line_b_n, line_a_n}, 32'h1);
        chk({31'h0, bus_irq_oe}, 32'h1);
        rdc(IMG_R_STATUS, 32'h0000_1200);
        wr(IMG_R_EDGE, 32'h0000_000F);
        settle();
        rdc(IMG_R_STATUS, 32'h0);
        wr(IMG_R_EDGE, 32'h0000_100F);
        settle();
        rdc(IMG_R_STATUS, 32'h0000_1200);
        wr(IMG_R_ENCLR, 32'h0000_1000);
        settle();
        chk({30'h0, line_b_n, line_a_n}, 32'h3);
        chk({31'h0, bus_irq_oe}, 32'h0);
        rdc(IMG_R_STATUS, 32'h0);
        wr(IMG_R_GENCFG, 32'h0);
        wr(IMG_R_EDGE, 32'h0200_000F);
        wr(IMG_R_INVERT, 32'h0200_0000);
        wr(IMG_R_INVERT, 32'h0);
        settle();
        rdc(IMG_R_STATUS, 32'h0200_0000);
        ext_en <= 1'b0;
        wr(IMG_R_PINDIR, 32'h0);
        wr(IMG_R_PINLVL, 32'h0000_000A);
        // The write lands at the edge the task returns on
        settle();
        chk({28'h0, gpio_oe}, 32'hF);
        chk({31'h0, hresp}, 32'h0);
        chk({31'h0, bus_irq_out}, 32'h0);
        chk({28'h0, gpio_out}, 32'hA);
        rdc(IMG_R_PINLVL, 32'h000A_000A);
        rdc(IMG_R_PINDIR, 32'h0000_03F0);
        stop_test();
    end
endmodule

`default_nettype wire
